// [rtl/sgc2_pkg.sv]
// package of offsets, field positions, reset values and limits for global control two
package sgc2_pkg;
  localparam logic [7:0] SGC2_ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] SGC2_ADDR_MASK = 8'hff;
  localparam int SGC2_BIT_VLAN_DISCARD = 7;
  localparam int SGC2_BIT_MCAST_EXCL = 6;
  localparam int SGC2_BIT_BP_CARRIER = 5;
  localparam int SGC2_BIT_FAIR = 4;
  localparam int SGC2_BIT_COLL_KEEP = 3;
  localparam int SGC2_BIT_OVERSIZE = 2;
  localparam int SGC2_BIT_SIZE_CHECK = 1;
  localparam int SGC2_BIT_PRIO_RSV = 0;
  // fixed reset bits; bits 3 and 1 come from straps
  localparam logic [7:0] SGC2_RESET_FIXED = 8'hf1;
  localparam logic [10:0] SGC2_LEN_OVERSIZE = 11'h77c;
  localparam logic [10:0] SGC2_LEN_DEFAULT = 11'h600;
  localparam logic [10:0] SGC2_LEN_TAGGED = 11'h5f2;
  localparam logic [10:0] SGC2_LEN_UNTAGGED = 11'h5ee;
  localparam logic [4:0] SGC2_COLL_LIMIT = 5'h10;
  localparam logic [5:0] SGC2_PRIO_BUFS = 6'h30;
  localparam logic [5:0] SGC2_PRIO_NONE = 6'h00;
endpackage : sgc2_pkg

// [rtl/sgc2_ctrl.sv]
// global control two register with wishbone slave and decoded policy outputs
// Behaviour
// RL1 - a set vlan discard bit blocks all boundary crossing, clear lets known unicast cross.
// RL2 - port mirroring is only guaranteed while the vlan discard bit is set.
// RL3 - with the multicast exclusion bit set the storm limiter counts broadcast frames only.
// RL4 - the backpressure bit picks carrier-sense jamming at 1 and collision backpressure at 0.
// RL5 - fair mode may drop frames from the non-flow-controlled source sharing a destination.
// RL6 - with fair mode off the flow-controlling source port is flow controlled instead.
// RL7 - the collision keep bit retries past 16 collisions at 1 and drops at 0, strap default.
// RL8 - the oversize bit accepts frames up to 1916 bytes and overrides the size check.
// RL9 - with the oversize bit clear the size check bit sets the length limit.
// RL10 - size check clear accepts up to 1536 bytes, its default taken from a strap.
// RL11 - size check set drops tagged frames above 1522 and untagged above 1518 bytes.
// RL12 - the priority reserve bit holds 48 buffers per output queue for high priority.
// RL13 - software should set the priority reserve bit when priority queueing is used.
// RL14 - both strap defaults are caught once as reset releases, then act as plain storage.
`timescale 1ns/1ps
module sgc2_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic collision_default_strap_i,
  input wire logic size_check_default_strap_i,
  output logic vlan_discard_all_o,
  output logic mirror_allowed_o,
  output logic storm_bcast_only_o,
  output logic bp_carrier_sense_o,
  output logic fair_drop_nonfc_o,
  output logic throttle_fc_src_o,
  output logic coll_keep_o,
  output logic [4:0] coll_limit_o,
  output logic [10:0] max_len_untagged_o,
  output logic [10:0] max_len_tagged_o,
  output logic [5:0] prio_rsv_bufs_o
);
  import sgc2_pkg::*;

  initial begin
    if (ADDR_W < 8) $error("sgc2_ctrl: ADDR_W below 8 cannot decode the register");
  end

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic strap_pend_r;

  // request decode; an unmapped address is acked and reads zero
  wire req_w = wb_cyc_i && wb_stb_i && !ack_r;
  wire hit_w = (wb_adr_i[7:0] & SGC2_ADDR_MASK) == SGC2_ADDR_CTRL2
    && (wb_adr_i == ADDR_W'(SGC2_ADDR_CTRL2));
  wire wr_w = req_w && wb_we_i && hit_w && wb_sel_i[0];

  // strap capture wins over a write: a bus request in the release cycle is neither written nor acked
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (strap_pend_r) begin
      ctrl_nxt[SGC2_BIT_COLL_KEEP] = collision_default_strap_i; // [RL7] [RL14]
      ctrl_nxt[SGC2_BIT_SIZE_CHECK] = size_check_default_strap_i; // [RL10] [RL14]
    end else if (wr_w) begin
      ctrl_nxt = wb_dat_i[7:0];
    end
  end

  wire [31:0] rd_sel_w = hit_w ? {24'h000000, ctrl_r} : 32'h00000000;

  always_comb begin
    rdat_nxt = rdat_r;
    if (req_w && !wb_we_i) rdat_nxt = rd_sel_w;
  end

  // register and bus flops; strap pins read as reset releases, not under reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= SGC2_RESET_FIXED;
      strap_pend_r <= 1'b1;
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      strap_pend_r <= 1'b0;
      ack_r <= req_w && !strap_pend_r;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // policy decode of the stored bits
  wire oversize_w = ctrl_r[SGC2_BIT_OVERSIZE];
  wire size_chk_w = ctrl_r[SGC2_BIT_SIZE_CHECK];
  wire [10:0] len_u_w = oversize_w ? SGC2_LEN_OVERSIZE : // [RL8]
    (size_chk_w ? SGC2_LEN_UNTAGGED : SGC2_LEN_DEFAULT); // [RL9] [RL10] [RL11]
  wire [10:0] len_t_w = oversize_w ? SGC2_LEN_OVERSIZE : // [RL8]
    (size_chk_w ? SGC2_LEN_TAGGED : SGC2_LEN_DEFAULT); // [RL9] [RL10] [RL11]
  wire [5:0] bufs_w = ctrl_r[SGC2_BIT_PRIO_RSV] ? SGC2_PRIO_BUFS : SGC2_PRIO_NONE; // [RL12]

  // outputs registered once more so the fabric sees flop-driven levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vlan_discard_all_o <= 1'b1;
      mirror_allowed_o <= 1'b1;
      storm_bcast_only_o <= 1'b1;
      bp_carrier_sense_o <= 1'b1;
      fair_drop_nonfc_o <= 1'b1;
      throttle_fc_src_o <= 1'b0;
      coll_keep_o <= 1'b0;
      coll_limit_o <= SGC2_COLL_LIMIT;
      max_len_untagged_o <= SGC2_LEN_DEFAULT;
      max_len_tagged_o <= SGC2_LEN_DEFAULT;
      prio_rsv_bufs_o <= SGC2_PRIO_BUFS;
    end else if (ce_i) begin
      vlan_discard_all_o <= ctrl_r[SGC2_BIT_VLAN_DISCARD]; // [RL1]
      mirror_allowed_o <= ctrl_r[SGC2_BIT_VLAN_DISCARD]; // [RL2]
      storm_bcast_only_o <= ctrl_r[SGC2_BIT_MCAST_EXCL]; // [RL3]
      bp_carrier_sense_o <= ctrl_r[SGC2_BIT_BP_CARRIER]; // [RL4]
      fair_drop_nonfc_o <= ctrl_r[SGC2_BIT_FAIR]; // [RL5]
      throttle_fc_src_o <= !ctrl_r[SGC2_BIT_FAIR]; // [RL6]
      coll_keep_o <= ctrl_r[SGC2_BIT_COLL_KEEP]; // [RL7]
      coll_limit_o <= SGC2_COLL_LIMIT;
      max_len_untagged_o <= len_u_w;
      max_len_tagged_o <= len_t_w;
      prio_rsv_bufs_o <= bufs_w; // [RL12] software is expected to set it [RL13]
    end
  end

  // checks; the per-bit follow checks need ce high in both cycles so freezes do not break them
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_vlan_follow: assert property (ce_i ##1 ce_i |-> // [RL1]
    vlan_discard_all_o == $past(ctrl_r[SGC2_BIT_VLAN_DISCARD]))
    else $error("vlan discard output does not follow its bit");
  chk_mirror_tie: assert property (mirror_allowed_o == vlan_discard_all_o) // [RL2]
    else $error("mirror permission differs from vlan discard");
  chk_storm_bcast: assert property (ce_i ##1 ce_i |-> // [RL3]
    storm_bcast_only_o == $past(ctrl_r[SGC2_BIT_MCAST_EXCL]))
    else $error("storm exclusion output wrong");
  chk_bp_style: assert property (ce_i ##1 ce_i |-> // [RL4]
    bp_carrier_sense_o == $past(ctrl_r[SGC2_BIT_BP_CARRIER]))
    else $error("backpressure style output wrong");
  chk_fair_excl: assert property (fair_drop_nonfc_o != throttle_fc_src_o) // [RL5] [RL6]
    else $error("fair drop and throttle both active or both idle");
  chk_strap_latch: assert property ($fell(rst_i) && ce_i |=> // [RL14]
    ctrl_r[SGC2_BIT_COLL_KEEP] == $past(collision_default_strap_i)
    && ctrl_r[SGC2_BIT_SIZE_CHECK] == $past(size_check_default_strap_i))
    else $error("strap defaults not captured at release");
  chk_coll_keep: assert property (ce_i ##1 ce_i |-> // [RL7]
    coll_keep_o == $past(ctrl_r[SGC2_BIT_COLL_KEEP]) && coll_limit_o == 5'h10)
    else $error("collision keep output wrong");
  chk_len_over: assert property (ce_i ##1 ce_i && $past(oversize_w) |-> // [RL8]
    max_len_untagged_o == 11'h77c && max_len_tagged_o == 11'h77c)
    else $error("oversize limit not 1916");
  chk_len_check: assert property (ce_i ##1 ce_i && !$past(oversize_w) |-> // [RL9] [RL11]
    max_len_tagged_o == ($past(size_chk_w) ? 11'h5f2 : 11'h600)
    && max_len_untagged_o == ($past(size_chk_w) ? 11'h5ee : 11'h600)) // [RL10]
    else $error("size check limits wrong");
  chk_prio_bufs: assert property (ce_i ##1 ce_i |-> // [RL12]
    prio_rsv_bufs_o == ($past(ctrl_r[SGC2_BIT_PRIO_RSV]) ? 6'h30 : 6'h00))
    else $error("priority reserve count wrong");
  // a frozen enable holds ack as it stands, so only a running cycle must end the pulse
  chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // every taken request is answered one running edge later
  chk_ack_timing: assert property (req_w && ce_i && !strap_pend_r |=> wb_ack_o)
    else $error("taken request not acked in the next cycle");

  // no ack appears without a request taken in the cycle before
  chk_ack_cause: assert property (ce_i && !(req_w && !strap_pend_r) |=> !wb_ack_o)
    else $error("ack without a taken request");

  // the strap cycle blocks the bus, a waiting request is answered later
  chk_strap_block: assert property (strap_pend_r |=> !wb_ack_o) // [RL14]
    else $error("request acked in the strap capture cycle");

  // capture happens once; the pending flag never comes back outside reset
  chk_strap_once: assert property (ce_i && !strap_pend_r |=> !strap_pend_r) // [RL14]
    else $error("strap capture pending again after release");

  // a full-byte write to the register lands at the acking edge
  chk_write_lands: assert property (ce_i && wr_w && !strap_pend_r |=> // [RL14]
    ctrl_r == $past(wb_dat_i[7:0]))
    else $error("register write did not land");

  // without a write the stored byte is plain storage and keeps its value
  chk_write_ignored: assert property (ce_i && !wr_w && !strap_pend_r |=> // [RL14]
    ctrl_r == $past(ctrl_r))
    else $error("register changed without a write");

  // a read of the register returns the stored byte in the low lane
  chk_read_hit: assert property (ce_i && req_w && !wb_we_i && hit_w |=>
    wb_dat_o == {24'h000000, $past(ctrl_r)})
    else $error("register read data wrong");

  // unmapped reads answer zero rather than stale data
  chk_read_miss: assert property (ce_i && req_w && !wb_we_i && !hit_w |=>
    wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  // upper lanes are never driven with anything but zero
  chk_read_upper: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("upper read lanes not zero");

  // a low enable freezes register, bus flops and policy outputs alike
  chk_freeze_regs: assert property (!ce_i |=>
    $stable(ctrl_r) && $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("register state moved while enable low");
  chk_freeze_outs: assert property (!ce_i |=>
    $stable(vlan_discard_all_o) && $stable(coll_keep_o) && $stable(max_len_tagged_o)
    && $stable(max_len_untagged_o) && $stable(prio_rsv_bufs_o))
    else $error("policy outputs moved while enable low");

  // mirror, throttle and fair drop outputs each track their source bit, checked per output
  chk_mirror_follow: assert property (ce_i ##1 ce_i |-> // [RL2]
    mirror_allowed_o == $past(ctrl_r[SGC2_BIT_VLAN_DISCARD]))
    else $error("mirror permission does not follow vlan discard bit");
  chk_throttle_follow: assert property (ce_i ##1 ce_i |-> // [RL6]
    throttle_fc_src_o == !$past(ctrl_r[SGC2_BIT_FAIR]))
    else $error("throttle output does not follow fair bit");
  chk_fair_follow: assert property (ce_i ##1 ce_i |-> // [RL5]
    fair_drop_nonfc_o == $past(ctrl_r[SGC2_BIT_FAIR]))
    else $error("fair drop output does not follow fair bit");

  // tagged frames never get a tighter limit than untagged ones
  chk_len_order: assert property (max_len_tagged_o >= max_len_untagged_o) // [RL11]
    else $error("tagged limit below untagged limit");

  cov_write: cover property (wr_w ##1 wb_ack_o);
  cov_read: cover property (req_w && !wb_we_i && hit_w ##1 wb_ack_o);
  cov_oversize: cover property (oversize_w && size_chk_w);
  cov_unmapped: cover property (req_w && !hit_w ##1 wb_ack_o);
  cov_strap_wait: cover property (strap_pend_r && req_w ##2 wb_ack_o);
endmodule : sgc2_ctrl

// [bench/test_switch_global_control_two.sv]
// random and corner bench for the global control two register block
`timescale 1ns/1ps
module test_switch_global_control_two;
  logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, ack, s_coll, s_size;
  logic vlan, mir, storm, bp, fair, thr, keep;
  logic [7:0] wb_adr, v, cur, a;
  logic [3:0] wb_sel, sl;
  logic [31:0] wb_dat, dat_o, rd, wd;
  logic [4:0] lim;
  logic [10:0] lu, lt;
  logic [5:0] bufs;
  logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h06, 8'h02}; // 8'hff sets priority reserve
  int seed = 75158;
  int n_errors = 0;
  int num_checks = 0;
  sgc2_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .collision_default_strap_i(s_coll),
    .size_check_default_strap_i(s_size), .vlan_discard_all_o(vlan), .mirror_allowed_o(mir),
    .storm_bcast_only_o(storm), .bp_carrier_sense_o(bp), .fair_drop_nonfc_o(fair),
    .throttle_fc_src_o(thr), .coll_keep_o(keep), .coll_limit_o(lim),
    .max_len_untagged_o(lu), .max_len_tagged_o(lt), .prio_rsv_bufs_o(bufs));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // limit chosen by oversize first, then the size check bit
  function automatic logic [10:0] exp_len(input logic [7:0] r, input logic tag);
    if (r[2]) return 11'h77c;
    if (!r[1]) return 11'h600;
    return tag ? 11'h5f2 : 11'h5ee;
  endfunction : exp_len
  // one classic cycle; ack sampled at the edge, request released at that same edge
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, ad, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1); // no answer counts as a mismatch
    rd = dat_o;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask : wb
  task automatic chk_outs(input logic [7:0] r);
    chk(vlan, r[7]);
    chk(mir, r[7]);
    chk(storm, r[6]);
    chk(bp, r[5]);
    chk(fair, r[4]);
    chk(thr, !r[4]);
    chk({keep, lim}, {r[3], 5'h10});
    chk(lu, exp_len(r, 1'b0));
    chk(lt, exp_len(r, 1'b1));
    chk(bufs, r[0] ? 6'h30 : 6'h00);
  endtask : chk_outs
  // watchdog well past the expected run length
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
  initial begin
    {ce_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = {4'b1000, 8'h00, 4'hf, 32'h0};
    rst_i = 1'b1;
    s_coll = $random(seed);
    s_size = $random(seed);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    cur = 8'hf1 | {4'h0, s_coll, 1'b0, s_size, 1'b0};
    chk_outs(cur);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, {24'h0, cur});
    // straps keep moving; only the value caught at reset may count
    for (int i = 0; i < 30; i++) begin
      v = (i < 4) ? corner[i] : 8'($random(seed));
      s_coll <= $random(seed);
      s_size <= $random(seed);
      a = (i % 5 == 4) ? 8'($random(seed)) : 8'h04;
      sl = (i % 7 == 6) ? 4'he : 4'hf;
      wd = $random(seed);
      wd[7:0] = v;
      wb(1'b1, a, wd, sl);
      if (a == 8'h04 && sl[0]) cur = v;
      wb(1'b0, a, 32'h0, 4'hf);
      chk(rd, (a == 8'h04) ? {24'h0, cur} : 32'h0);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk(rd, {24'h0, cur});
      chk_outs(cur);
    end
    stop_test;
  end
endmodule : test_switch_global_control_two
